// ===== hdl/irq_ctrl.v
// Interrupt flags, enables and request logic with an APB register port
// Function
// - An accepted request suspends the main program so the CPU services it.
// - Sources: pin, two time bases, EEPROM, A/D, standard and periodic timers.
// - Edge select 00 off, 01 rising, 10 falling, 11 both edges.
// - Edge select bits 7..2 read as zero.
// - Control 0 flags: bit 6 time base 1, bit 5 time base 0, bit 4 pin.
// - Control 0 enables: bits 3,2,1 time bases and pin, bit 0 global.
// - Control 1 holds group1, A/D, EEPROM, group0 flags and matching enables.
// - Group registers: compare A/P flags bits 5,4, enables bits 1,0.
// - Flags set on their event regardless of enables (group flags here set only from an enabled member flag); software owns enables.
// - Control 0 bit 7 reads as zero.
// - Group register bits 7..6 and 3..2 read as zero.
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "irq_consts.vh"
module irq_ctrl (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // External interrupt pin
  input wire ext_int_pin,
  // Internal event pulses, one cycle each
  input wire timebase0_evt,
  input wire timebase1_evt,
  input wire adc_evt,
  input wire eeprom_evt,
  input wire std_timer_cmpa_evt,
  input wire std_timer_cmpp_evt,
  input wire per_timer_cmpa_evt,
  input wire per_timer_cmpp_evt,
  // CPU core handshake
  input wire irq_ack,
  output reg irq_req,
  output reg [3:0] irq_vector
);
  // Software-owned enables
  reg [1:0] edge_mode_q;
  reg global_irq_enable_q;
  reg pin_irq_enable_q;
  reg timebase0_enable_q;
  reg timebase1_enable_q;
  reg adc_irq_enable_q;
  reg eeprom_irq_enable_q;
  reg group0_enable_q;
  reg group1_enable_q;
  reg std_timer_cmpa_enable_q;
  reg std_timer_cmpp_enable_q;
  reg per_timer_cmpa_enable_q;
  reg per_timer_cmpp_enable_q;
  // Flags from the flag instances
  wire pin_irq_flag;
  wire timebase0_flag;
  wire timebase1_flag;
  wire adc_irq_flag;
  wire eeprom_irq_flag;
  wire group0_flag;
  wire group1_flag;
  wire std_timer_cmpa_flag;
  wire std_timer_cmpp_flag;
  wire per_timer_cmpa_flag;
  wire per_timer_cmpp_flag;
  wire pin_hit;
  // Bus decode
  wire setup_wr;
  wire wr_edge;
  wire wr_pc0;
  wire wr_pc1;
  wire wr_mf0;
  wire wr_mf1;
  wire addr_ok;
  wire [7:0] wb;
  reg [7:0] rd_byte;
  wire [7:0] edge_rd;
  wire [7:0] pc0_rd;
  wire [7:0] pc1_rd;
  wire [7:0] mf0_rd;
  wire [7:0] mf1_rd;
  // Service logic
  wire grp0_set;
  wire grp1_set;
  wire [6:0] live;
  reg [3:0] pick_vec;
  wire [3:0] clr_vec;
  reg [3:0] vec_d;
  reg req_d;
  reg in_service_q;
  reg cur_live;
  wire ack_take;

  // Writes happen on the access cycle; pready is high for the access cycle only, no wait states
  assign setup_wr = psel & penable & pwrite;
  assign wb = pwdata[7:0];
  assign wr_edge = setup_wr & (paddr == `ADDR_EDGE_SEL);
  assign wr_pc0 = setup_wr & (paddr == `ADDR_PRI_CTRL0);
  assign wr_pc1 = setup_wr & (paddr == `ADDR_PRI_CTRL1);
  assign wr_mf0 = setup_wr & (paddr == `ADDR_MF_GROUP0);
  assign wr_mf1 = setup_wr & (paddr == `ADDR_MF_GROUP1);
  assign addr_ok = (paddr == `ADDR_EDGE_SEL) | (paddr == `ADDR_PRI_CTRL0) |
    (paddr == `ADDR_PRI_CTRL1) | (paddr == `ADDR_MF_GROUP0) |
    (paddr == `ADDR_MF_GROUP1) | (paddr == `ADDR_IRQ_STATUS);

  // Pin edge detection
  edge_detect u_pin (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin_in(ext_int_pin),
    .mode(edge_mode_q),
    .hit(pin_hit)
  );

  // Group flags follow any enabled member flag
  assign grp0_set = (std_timer_cmpa_flag & std_timer_cmpa_enable_q) |
    (std_timer_cmpp_flag & std_timer_cmpp_enable_q);
  assign grp1_set = (per_timer_cmpa_flag & per_timer_cmpa_enable_q) |
    (per_timer_cmpp_flag & per_timer_cmpp_enable_q);

  // Acceptance by the core clears the flag of the serviced primary source, except a group flag whose enabled member flag is still set
  assign ack_take = irq_ack & irq_req;
  assign clr_vec = ack_take ? irq_vector : `VEC_NONE;

  // Flags set on their own events, independent of enables except the member enables that gate the group flags
  irq_flag u_pin_f (.ref_clk(ref_clk), .reset_n(reset_n), .set_pulse(pin_hit),
    .wr_en(wr_pc0 | (clr_vec == `VEC_PIN)), .wr_val(wr_pc0 & wb[`PC0_PINF]),
    .flag_q(pin_irq_flag));
  irq_flag u_tb0_f (.ref_clk(ref_clk), .reset_n(reset_n), .set_pulse(timebase0_evt),
    .wr_en(wr_pc0 | (clr_vec == `VEC_TB0)), .wr_val(wr_pc0 & wb[`PC0_TIMEBASE0_FLAG]),
    .flag_q(timebase0_flag));
  irq_flag u_tb1_f (.ref_clk(ref_clk), .reset_n(reset_n), .set_pulse(timebase1_evt),
    .wr_en(wr_pc0 | (clr_vec == `VEC_TB1)), .wr_val(wr_pc0 & wb[`PC0_TIMEBASE1_FLAG]),
    .flag_q(timebase1_flag));
  irq_flag u_ad_f (.ref_clk(ref_clk), .reset_n(reset_n), .set_pulse(adc_evt),
    .wr_en(wr_pc1 | (clr_vec == `VEC_AD)), .wr_val(wr_pc1 & wb[`PC1_ADF]),
    .flag_q(adc_irq_flag));
  irq_flag u_ee_f (.ref_clk(ref_clk), .reset_n(reset_n), .set_pulse(eeprom_evt),
    .wr_en(wr_pc1 | (clr_vec == `VEC_EE)), .wr_val(wr_pc1 & wb[`PC1_EEF]),
    .flag_q(eeprom_irq_flag));
  irq_flag u_mf0_f (.ref_clk(ref_clk), .reset_n(reset_n), .set_pulse(grp0_set),
    .wr_en(wr_pc1 | (clr_vec == `VEC_MF0)), .wr_val(wr_pc1 & wb[`PC1_GROUP0_FLAG]),
    .flag_q(group0_flag));
  irq_flag u_mf1_f (.ref_clk(ref_clk), .reset_n(reset_n), .set_pulse(grp1_set),
    .wr_en(wr_pc1 | (clr_vec == `VEC_MF1)), .wr_val(wr_pc1 & wb[`PC1_GROUP1_FLAG]),
    .flag_q(group1_flag));
  // Member flags stay set until software clears them; their enables only
  // gate the group flag, so a disabled member still shows as pending
  irq_flag u_sa_f (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .set_pulse(std_timer_cmpa_evt),
    .wr_en(wr_mf0),
    .wr_val(wb[`MF_CMPA_F]),
    .flag_q(std_timer_cmpa_flag)
  );
  irq_flag u_sp_f (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .set_pulse(std_timer_cmpp_evt),
    .wr_en(wr_mf0),
    .wr_val(wb[`MF_CMPP_F]),
    .flag_q(std_timer_cmpp_flag)
  );
  irq_flag u_pa_f (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .set_pulse(per_timer_cmpa_evt),
    .wr_en(wr_mf1),
    .wr_val(wb[`MF_CMPA_F]),
    .flag_q(per_timer_cmpa_flag)
  );
  irq_flag u_pp_f (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .set_pulse(per_timer_cmpp_evt),
    .wr_en(wr_mf1),
    .wr_val(wb[`MF_CMPP_F]),
    .flag_q(per_timer_cmpp_flag)
  );

  // Enable registers, written by software only
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      edge_mode_q <= `RST_EDGE;
      global_irq_enable_q <= 1'b0;
      pin_irq_enable_q <= 1'b0;
      timebase0_enable_q <= 1'b0;
      timebase1_enable_q <= 1'b0;
      adc_irq_enable_q <= 1'b0;
      eeprom_irq_enable_q <= 1'b0;
      group0_enable_q <= 1'b0;
      group1_enable_q <= 1'b0;
      std_timer_cmpa_enable_q <= 1'b0;
      std_timer_cmpp_enable_q <= 1'b0;
      per_timer_cmpa_enable_q <= 1'b0;
      per_timer_cmpp_enable_q <= 1'b0;
    end else begin
      if (wr_edge) begin
        edge_mode_q <= wb[`EDGE_SEL_HI:`EDGE_SEL_LO];
      end
      if (wr_pc0) begin
        timebase1_enable_q <= wb[`PC0_TIMEBASE1_ENABLE];
        timebase0_enable_q <= wb[`PC0_TIMEBASE0_ENABLE];
        pin_irq_enable_q <= wb[`PC0_PINE];
        global_irq_enable_q <= wb[`PC0_GIE];
      end
      if (wr_pc1) begin
        group1_enable_q <= wb[`PC1_GROUP1_ENABLE];
        adc_irq_enable_q <= wb[`PC1_ADE];
        eeprom_irq_enable_q <= wb[`PC1_EEE];
        group0_enable_q <= wb[`PC1_GROUP0_ENABLE];
      end
      if (wr_mf0) begin
        std_timer_cmpa_enable_q <= wb[`MF_CMPA_E];
        std_timer_cmpp_enable_q <= wb[`MF_CMPP_E];
      end
      if (wr_mf1) begin
        per_timer_cmpa_enable_q <= wb[`MF_CMPA_E];
        per_timer_cmpp_enable_q <= wb[`MF_CMPP_E];
      end
    end
  end

  // Read images; unimplemented bits are tied to zero
  assign edge_rd = {6'h00, edge_mode_q};
  assign pc0_rd = {1'b0, timebase1_flag, timebase0_flag, pin_irq_flag,
    timebase1_enable_q, timebase0_enable_q, pin_irq_enable_q, global_irq_enable_q};
  assign pc1_rd = {group1_flag, adc_irq_flag, eeprom_irq_flag, group0_flag,
    group1_enable_q, adc_irq_enable_q, eeprom_irq_enable_q, group0_enable_q};
  assign mf0_rd = {2'h0, std_timer_cmpa_flag, std_timer_cmpp_flag, 2'h0,
    std_timer_cmpa_enable_q, std_timer_cmpp_enable_q};
  assign mf1_rd = {2'h0, per_timer_cmpa_flag, per_timer_cmpp_flag, 2'h0,
    per_timer_cmpa_enable_q, per_timer_cmpp_enable_q};

  // Read mux
  always @* begin
    case (paddr)
      `ADDR_EDGE_SEL: rd_byte = edge_rd;
      `ADDR_PRI_CTRL0: rd_byte = pc0_rd;
      `ADDR_PRI_CTRL1: rd_byte = pc1_rd;
      `ADDR_MF_GROUP0: rd_byte = mf0_rd;
      `ADDR_MF_GROUP1: rd_byte = mf1_rd;
      `ADDR_IRQ_STATUS: rd_byte = {3'h0, in_service_q, irq_vector};
      default: rd_byte = `RST_BYTE;
    endcase
  end

  // Registered APB answer; read data is captured in the setup cycle
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= `RST_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (psel & ~penable & ~pwrite) begin
        prdata <= {24'h000000, rd_byte};
      end else begin
        prdata <= `RST_WORD;
      end
    end
  end

  // Requests gated by flag, own enable and global enable (group enable path)
  assign live[0] = global_irq_enable_q & pin_irq_flag & pin_irq_enable_q;
  assign live[1] = global_irq_enable_q & group0_flag & group0_enable_q;
  assign live[2] = global_irq_enable_q & eeprom_irq_flag & eeprom_irq_enable_q;
  assign live[3] = global_irq_enable_q & adc_irq_flag & adc_irq_enable_q;
  assign live[4] = global_irq_enable_q & group1_flag & group1_enable_q;
  assign live[5] = global_irq_enable_q & timebase0_flag & timebase0_enable_q;
  assign live[6] = global_irq_enable_q & timebase1_flag & timebase1_enable_q;

  // Whether the source behind the standing vector is still live
  always @* begin
    case (irq_vector)
      `VEC_PIN: cur_live = live[0];
      `VEC_MF0: cur_live = live[1];
      `VEC_EE: cur_live = live[2];
      `VEC_AD: cur_live = live[3];
      `VEC_MF1: cur_live = live[4];
      `VEC_TB0: cur_live = live[5];
      `VEC_TB1: cur_live = live[6];
      default: cur_live = 1'b0;
    endcase
  end

  // Fixed priority, lowest vector first
  always @* begin
    if (live[0]) begin
      pick_vec = `VEC_PIN;
    end else if (live[1]) begin
      pick_vec = `VEC_MF0;
    end else if (live[2]) begin
      pick_vec = `VEC_EE;
    end else if (live[3]) begin
      pick_vec = `VEC_AD;
    end else if (live[4]) begin
      pick_vec = `VEC_MF1;
    end else if (live[5]) begin
      pick_vec = `VEC_TB0;
    end else if (live[6]) begin
      pick_vec = `VEC_TB1;
    end else begin
      pick_vec = `VEC_NONE;
    end
  end

  // Request stays up until the core accepts; in service blocks nesting
  // until software writes control 0 again, as the core would on return.
  // A request whose own source was cleared or disabled is withdrawn, so an
  // acknowledge never clears a flag other than the one that asked
  always @* begin
    req_d = irq_req;
    vec_d = irq_vector;
    if (ack_take) begin
      req_d = 1'b0;
    end else if (!irq_req && !in_service_q) begin
      req_d = (pick_vec != `VEC_NONE);
      vec_d = pick_vec;
    end else if (irq_req && !cur_live) begin
      req_d = 1'b0;
    end
  end

  // Request output and service state
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_req <= 1'b0;
      irq_vector <= `VEC_NONE;
      in_service_q <= 1'b0;
    end else begin
      irq_req <= req_d;
      irq_vector <= vec_d;
      if (ack_take) begin
        in_service_q <= 1'b1;
      end else if (wr_pc0) begin
        in_service_q <= 1'b0;
      end
    end
  end
endmodule // irq_ctrl

// ===== hdl/irq_consts.vh
// Register offsets, field positions and reset values of the interrupt block
`ifndef IRQ_CONSTS_VH
`define IRQ_CONSTS_VH
// Register byte addresses on the APB bus
`define ADDR_EDGE_SEL 12'h000
`define ADDR_PRI_CTRL0 12'h004
`define ADDR_PRI_CTRL1 12'h008
`define ADDR_MF_GROUP0 12'h00c
`define ADDR_MF_GROUP1 12'h010
`define ADDR_IRQ_STATUS 12'h014
// Reset values
`define RST_BYTE 8'h00
`define RST_EDGE 2'h0
// Edge select encodings
`define EDGE_OFF 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
// Edge select field position within its register
`define EDGE_SEL_HI 1
`define EDGE_SEL_LO 0
// Reset value of the read data word
`define RST_WORD 32'h00000000
// Primary control 0 fields
`define PC0_TIMEBASE1_FLAG 6
`define PC0_TIMEBASE0_FLAG 5
`define PC0_PINF 4
`define PC0_TIMEBASE1_ENABLE 3
`define PC0_TIMEBASE0_ENABLE 2
`define PC0_PINE 1
`define PC0_GIE 0
// Primary control 1 fields
`define PC1_GROUP1_FLAG 7
`define PC1_ADF 6
`define PC1_EEF 5
`define PC1_GROUP0_FLAG 4
`define PC1_GROUP1_ENABLE 3
`define PC1_ADE 2
`define PC1_EEE 1
`define PC1_GROUP0_ENABLE 0
// Multi-function group fields
`define MF_CMPA_F 5
`define MF_CMPP_F 4
`define MF_CMPA_E 1
`define MF_CMPP_E 0
// Vector numbers of the sources, in priority order
`define VEC_PIN 4'h1
`define VEC_MF0 4'h2
`define VEC_EE 4'h3
`define VEC_AD 4'h4
`define VEC_MF1 4'h5
`define VEC_TB0 4'h6
`define VEC_TB1 4'h7
`define VEC_NONE 4'h0
`endif

// ===== hdl/irq_flag.v
// One sticky request flag: hardware set, software write
`timescale 1ns/1ps
module irq_flag (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Set and software access
  input wire set_pulse,
  input wire wr_en,
  input wire wr_val,
  output reg flag_q
);
  // Set wins over a software clear in the same cycle so no event is lost
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= 1'b0;
    end else if (set_pulse) begin
      flag_q <= 1'b1;
    end else if (wr_en) begin
      flag_q <= wr_val;
    end
  end
endmodule // irq_flag

// ===== hdl/edge_detect.v
// Pin synchroniser and selectable edge detector
`timescale 1ns/1ps
`include "irq_consts.vh"
module edge_detect (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Pin and mode
  input wire pin_in,
  input wire [1:0] mode,
  output reg hit
);
  reg sync1_q;
  reg sync2_q;
  reg last_q;
  wire rise;
  wire fall;
  // Two flops before use; the edge logic compares sync2_q with last_q
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      last_q <= sync2_q;
    end
  end
  assign rise = sync2_q & ~last_q;
  assign fall = ~sync2_q & last_q;
  // Mode decode
  always @* begin
    case (mode)
      `EDGE_OFF: hit = 1'b0;
      `EDGE_RISE: hit = rise;
      `EDGE_FALL: hit = fall;
      `EDGE_BOTH: hit = rise | fall;
      default: hit = 1'b0;
    endcase
  end
endmodule // edge_detect

// ===== verif/irq_ctrl_asserts.sv
// Port-level checks of the interrupt block: APB timing, read-as-zero bits, core handshake
`timescale 1ns/1ps
module irq_ctrl_asserts (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // APB slave side
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Core handshake
  input wire irq_ack,
  input wire irq_req,
  input wire [3:0] irq_vector
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // Read data is only meaningful in the completing access cycle
  wire rd_done = pready && !pwrite;

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence

  a_setup_answer: assert property (setup_s |=> answer_s)
    else $error("setup not answered by one single ready cycle");
  a_ack_drops_req: assert property (irq_req && irq_ack |=> !irq_req [*2])
    else $error("request still up after acknowledge");
  a_vector_valid: assert property (irq_req |-> irq_vector inside {[4'h1:4'h7]})
    else $error("request without a source vector");
  a_edge_high_zero: assert property (rd_done && paddr == 12'h000 |-> prdata[7:2] == 6'h00)
    else $error("edge select upper bits not zero");
  a_ctrl0_top_zero: assert property (rd_done && paddr == 12'h004 |-> !prdata[7])
    else $error("control 0 bit 7 not zero");
  a_group_gaps_zero: assert property (rd_done && (paddr == 12'h00c || paddr == 12'h010)
    |-> prdata[7:6] == 2'h0 && prdata[3:2] == 2'h0)
    else $error("group register gap bits not zero");
  a_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("read data above bit 7 not zero");
  a_unmapped_err: assert property (pready && paddr > 12'h014 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule // irq_ctrl_asserts

bind irq_ctrl irq_ctrl_asserts irq_ctrl_asserts_inst (.ref_clk(ref_clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq_ack(irq_ack), .irq_req(irq_req),
  .irq_vector(irq_vector));

// ===== verif/cpu_core_model.sv
// Behavioural CPU core that services requests after a chosen delay
`timescale 1ns/1ps
module cpu_core_model (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Request side
  input wire irq_req,
  input wire [3:0] irq_vector,
  input wire [3:0] ack_delay,
  // Answer and record
  output reg irq_ack,
  output reg [3:0] last_vec,
  output reg [7:0] serviced
);
  reg [3:0] wait_q;
  // One-cycle ack so a single request is never serviced twice
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_ack <= 1'b0;
      last_vec <= 4'h0;
      serviced <= 8'h00;
      wait_q <= 4'h0;
    end else if (irq_ack || !irq_req) begin
      irq_ack <= 1'b0;
      wait_q <= 4'h0;
    end else if (wait_q >= ack_delay) begin
      irq_ack <= 1'b1;
      last_vec <= irq_vector;
      serviced <= serviced + 8'h01;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule // cpu_core_model

// ===== verif/tb.sv
// Self-checking bench: register map, per-source requests and pin edge modes
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic ext_pin = 1'b0;
  logic [7:0] evt = 8'h00;
  logic [3:0] dly = 4'h0;
  wire [31:0] prdata;
  wire pready, pslverr, irq_ack, irq_req;
  wire [3:0] irq_vector, last_vec;
  wire [7:0] serviced;
  int err_total = 0;
  int compares = 0;
  logic [31:0] rd;
  logic err;
  logic [7:0] svc_prev;
  // Per source: flag register, flag byte, group, control 1 and control 0 writes, vector
  logic [7:0] fa [0:7] = '{8'h04, 8'h04, 8'h08, 8'h08, 8'h0c, 8'h0c, 8'h10, 8'h10};
  logic [7:0] fm [0:7] = '{8'h20, 8'h40, 8'h40, 8'h20, 8'h20, 8'h10, 8'h20, 8'h10};
  logic [7:0] gd [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h22, 8'h11, 8'h22, 8'h11};
  logic [7:0] c1 [0:7] = '{8'h00, 8'h00, 8'h44, 8'h22, 8'h01, 8'h01, 8'h08, 8'h08};
  logic [7:0] c0 [0:7] = '{8'h25, 8'h49, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
  logic [3:0] vec [0:7] = '{4'h6, 4'h7, 4'h4, 4'h3, 4'h2, 4'h2, 4'h5, 4'h5};

  irq_ctrl irq_ctrl_inst (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_int_pin(ext_pin), .timebase0_evt(evt[0]),
    .timebase1_evt(evt[1]), .adc_evt(evt[2]), .eeprom_evt(evt[3]),
    .std_timer_cmpa_evt(evt[4]), .std_timer_cmpp_evt(evt[5]), .per_timer_cmpa_evt(evt[6]),
    .per_timer_cmpp_evt(evt[7]), .irq_ack(irq_ack), .irq_req(irq_req),
    .irq_vector(irq_vector));
  cpu_core_model cpu_core_model_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .irq_req(irq_req), .irq_vector(irq_vector), .ack_delay(dly), .irq_ack(irq_ack),
    .last_vec(last_vec), .serviced(serviced));

  always #5 ref_clk = ~ref_clk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; the request is held until ready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    paddr <= {4'h0, a};
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Members first, so a group flag cannot re-set behind the clear
  task automatic clear_all;
    apb(8'h0c, 1'b1, 32'h0);
    apb(8'h10, 1'b1, 32'h0);
    apb(8'h08, 1'b1, 32'h0);
    apb(8'h04, 1'b1, 32'h0);
  endtask

  // A hang here is ended by the watchdog, which fails the run
  task automatic wait_service(input logic [7:0] prev);
    while (serviced === prev) begin
      @(posedge ref_clk);
    end
  endtask

  task automatic final_report;
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    final_report;
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Reset values, then an unmapped read
    for (int a = 0; a < 6; a++) begin
      apb(8'(a * 4), 1'b0, 32'h0);
      check("reset value", rd, 32'h0);
    end
    apb(8'h18, 1'b0, 32'h0);
    check("unmapped error", err, 1'b1);
    // All-ones writes with global enable off
    apb(8'h00, 1'b1, 32'hffffffff);
    apb(8'h0c, 1'b1, 32'hffffffff);
    apb(8'h04, 1'b1, 32'h000000fe);
    apb(8'h00, 1'b0, 32'h0);
    check("edge select", rd, 32'h3);
    apb(8'h0c, 1'b0, 32'h0);
    check("group0", rd, 32'h33);
    apb(8'h08, 1'b0, 32'h0);
    check("ctrl1", rd, 32'h10);
    apb(8'h04, 1'b0, 32'h0);
    check("ctrl0", rd, 32'h7e);
    check("no request", irq_req, 1'b0);
    clear_all;
    apb(8'h00, 1'b1, 32'h0);
    // Each event-pulse source (not the pin): flag without enables, then a serviced request
    for (int i = 0; i < 8; i++) begin
      dly <= 4'(i);
      evt[i] <= 1'b1;
      @(posedge ref_clk);
      evt <= 8'h00;
      apb(fa[i], 1'b0, 32'h0);
      check("flag set", rd, {24'h0, fm[i]});
      check("held off", irq_req, 1'b0);
      if (i > 3) begin
        apb(8'h08, 1'b0, 32'h0);
        check("group idle", rd, 32'h0);
        apb(fa[i], 1'b1, {24'h0, gd[i]});
      end
      apb(8'h08, 1'b1, {24'h0, c1[i]});
      svc_prev = serviced;
      apb(8'h04, 1'b1, {24'h0, c0[i]});
      wait_service(svc_prev);
      check("vector", last_vec, vec[i]);
      apb(8'h14, 1'b0, 32'h0);
      check("in service", rd, {24'h0, 4'h1, vec[i]});
      clear_all;
    end
    // Edge modes: a rising then a falling pin change in each
    for (int m = 0; m < 4; m++) begin
      apb(8'h00, 1'b1, 32'(m));
      for (int e = 0; e < 2; e++) begin
        ext_pin <= ~ext_pin;
        repeat (4) @(posedge ref_clk);
        apb(8'h04, 1'b0, 32'h0);
        check("pin edge", rd, (m == e + 1 || m == 3) ? 32'h10 : 32'h0);
        apb(8'h04, 1'b1, 32'h0);
      end
    end
    // Pin request in rising mode reaches the core
    apb(8'h00, 1'b1, 32'h1);
    apb(8'h04, 1'b1, 32'h03);
    svc_prev = serviced;
    ext_pin <= 1'b1;
    wait_service(svc_prev);
    check("pin vector", last_vec, 4'h1);
    final_report;
  end
endmodule // tb
